// >>> src/rcr_top.sv
`default_nettype none
// Overview of operation
// - fifth sleep field 00 keeps normal code
// - fifth field 11 uses sleep code pin low
// - sixth field 11 sleep when pin low
// - sleep pin choice is factory fixed
// - bit 1 picks automatic or forced PWM
// - fifth bit 0 clear forces regulator off
// - sixth bit 0 clear overrides its enable pin
// - sixth register at 27h, factory reset
module rcr_top (
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire logic [7:0] E_STRAP,
    input wire logic [7:0] F_STRAP,
    input wire logic E_SLEEP_PIN_SEL,
    input wire logic F_SLEEP_PIN_SEL,
    input wire logic WR_EN,
    input wire logic [7:0] ADDR,
    input wire logic [7:0] WR_DATA,
    output logic [7:0] RD_DATA,
    input wire logic FIRST_SLEEP_PIN,
    input wire logic SECOND_SLEEP_PIN,
    input wire logic [5:0] ENABLE_INPUT_PINS,
    input wire logic E_PIN_ENABLE,
    input wire logic F_PIN_ENABLE,
    output logic E_USE_SLEEP_CODE,
    output logic F_USE_SLEEP_CODE,
    output logic E_PWM_FORCE,
    output logic F_PWM_FORCE,
    output logic E_RUN,
    output logic F_RUN
);
    logic load_ff;
    logic [1:0] sleep_raw;
    logic [1:0] sl1_ff;
    logic [1:0] sl2_ff;
    logic [1:0] sl3_ff;
    logic [1:0] sleep_ff;
    logic [1:0] en_raw;
    logic [1:0] en1_ff;
    logic [1:0] en2_ff;
    logic [1:0] en3_ff;
    logic [1:0] pin_en_ff;
    logic e_hit;
    logic f_hit;
    logic e_wr;
    logic f_wr;
    logic [7:0] e_ctrl;
    logic [7:0] f_ctrl;
    logic e_soft;
    logic f_soft;
    logic e_sel;
    logic f_sel;
    logic [7:0] rd_ff;
    logic [7:0] nxt_rd;

    // one-shot strap capture after reset release; straps are static
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            load_ff <= 1'b1;
        end else begin
            load_ff <= 1'b0;
        end
    end

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            e_sel <= 1'b0;
            f_sel <= 1'b0;
        end else if (load_ff) begin
            e_sel <= E_SLEEP_PIN_SEL;
            f_sel <= F_SLEEP_PIN_SEL;
        end
    end

    // sleep pins are asynchronous: three stages, a change counts once two and three agree
    // reset idles them high so no sleep request is seen before real samples arrive
    assign sleep_raw = {FIRST_SLEEP_PIN, SECOND_SLEEP_PIN};
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_sleep_sync
            always_ff @(posedge CORE_CLK or posedge RST) begin
                if (RST) begin
                    sl1_ff[g] <= 1'b1;
                    sl2_ff[g] <= 1'b1;
                    sl3_ff[g] <= 1'b1;
                    sleep_ff[g] <= 1'b1;
                end else begin
                    sl1_ff[g] <= sleep_raw[g];
                    sl2_ff[g] <= sl1_ff[g];
                    sl3_ff[g] <= sl2_ff[g];
                    if (sl2_ff[g] == sl3_ff[g]) begin
                        sleep_ff[g] <= sl3_ff[g];
                    end
                end
            end
        end
    endgenerate

    // pin enable requests: same filter, reset low so nothing runs before the pins are seen
    assign en_raw = {F_PIN_ENABLE, E_PIN_ENABLE};
    generate
        for (g = 0; g < 2; g++) begin : g_enable_sync
            always_ff @(posedge CORE_CLK or posedge RST) begin
                if (RST) begin
                    en1_ff[g] <= 1'b0;
                    en2_ff[g] <= 1'b0;
                    en3_ff[g] <= 1'b0;
                    pin_en_ff[g] <= 1'b0;
                end else begin
                    en1_ff[g] <= en_raw[g];
                    en2_ff[g] <= en1_ff[g];
                    en3_ff[g] <= en2_ff[g];
                    if (en2_ff[g] == en3_ff[g]) begin
                        pin_en_ff[g] <= en3_ff[g];
                    end
                end
            end
        end
    endgenerate

    // decode once so the write strobes and the read mux agree on the map
    assign e_hit = (ADDR == rcr_pkg::REG_E_CTRL_ADDR);
    assign f_hit = (ADDR == rcr_pkg::REG_F_CTRL_ADDR);
    assign e_wr = WR_EN && e_hit;
    assign f_wr = WR_EN && f_hit;

    rcr_chan u_e (
        .clk(CORE_CLK),
        .rst(RST),
        .load_strap(load_ff),
        .strap_value(E_STRAP),
        .wr_en(e_wr),
        .wr_data(WR_DATA),
        .sleep_pin_sel(e_sel),
        .first_sleep_pin(sleep_ff[1]),
        .second_sleep_pin(sleep_ff[0]),
        .ctrl(e_ctrl),
        .use_sleep_code(E_USE_SLEEP_CODE),
        .pwm_force(E_PWM_FORCE),
        .soft_enable(e_soft)
    );

    rcr_chan u_f (
        .clk(CORE_CLK),
        .rst(RST),
        .load_strap(load_ff),
        .strap_value(F_STRAP),
        .wr_en(f_wr),
        .wr_data(WR_DATA),
        .sleep_pin_sel(f_sel),
        .first_sleep_pin(sleep_ff[1]),
        .second_sleep_pin(sleep_ff[0]),
        .ctrl(f_ctrl),
        .use_sleep_code(F_USE_SLEEP_CODE),
        .pwm_force(F_PWM_FORCE),
        .soft_enable(f_soft)
    );

    // the disable bit wins over any enable pin
    assign E_RUN = e_soft && pin_en_ff[0];
    assign F_RUN = f_soft && pin_en_ff[1];

    // unmapped offsets read zero so probing software never sees a stale byte
    always_comb begin
        nxt_rd = rcr_pkg::READ_ZERO;
        if (e_hit) begin
            nxt_rd = e_ctrl;
        end else if (f_hit) begin
            nxt_rd = f_ctrl;
        end
    end

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            rd_ff <= rcr_pkg::READ_ZERO;
        end else begin
            rd_ff <= nxt_rd;
        end
    end

    assign RD_DATA = rd_ff;
endmodule // rcr_top
`default_nettype wire

// >>> src/rcr_pkg.sv
`default_nettype none
package rcr_pkg;
    localparam logic [7:0] REG_F_CTRL_ADDR = 8'h27;
    localparam logic [7:0] REG_E_CTRL_ADDR = 8'h26;
    localparam int SLEEP_MSB = 5;
    localparam int SLEEP_LSB = 4;
    localparam int RSVD_MSB = 3;
    localparam int RSVD_LSB = 2;
    localparam int MODE_BIT = 1;
    localparam int ENABLE_BIT = 0;
    localparam logic [1:0] SLEEP_OFF = 2'h0;
    localparam logic [1:0] SLEEP_ON = 2'h3;
    localparam logic [7:0] CTRL_WMASK = 8'h3F;
    localparam logic [7:0] CTRL_RESET = 8'h0D;
    localparam logic [7:0] READ_ZERO = 8'h00;
    typedef enum logic {RCR_PIN_FIRST, RCR_PIN_SECOND} rcr_pin_e;
endpackage : rcr_pkg
`default_nettype wire

// >>> src/rcr_chan.sv
`default_nettype none
// one regulator's control register and its derived controls
module rcr_chan (
    input wire logic clk,
    input wire logic rst,
    input wire logic load_strap,
    input wire logic [7:0] strap_value,
    input wire logic wr_en,
    input wire logic [7:0] wr_data,
    input wire logic sleep_pin_sel,
    input wire logic first_sleep_pin,
    input wire logic second_sleep_pin,
    output logic [7:0] ctrl,
    output logic use_sleep_code,
    output logic pwm_force,
    output logic soft_enable
);
    logic [7:0] ctrl_ff;
    logic pin_level;

    // reset takes a constant; the factory pattern lands one cycle after release
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_ff <= rcr_pkg::CTRL_RESET;
        end else if (load_strap) begin
            ctrl_ff <= strap_value & rcr_pkg::CTRL_WMASK;
        end else if (wr_en) begin
            ctrl_ff <= wr_data & rcr_pkg::CTRL_WMASK;
        end
    end

    assign ctrl = ctrl_ff;
    assign pin_level = (sleep_pin_sel == rcr_pkg::RCR_PIN_SECOND) ?
        second_sleep_pin : first_sleep_pin;
    // reserved codes 01/10 fall back to the normal code
    assign use_sleep_code = (ctrl_ff[rcr_pkg::SLEEP_MSB:rcr_pkg::SLEEP_LSB]
        == rcr_pkg::SLEEP_ON) && !pin_level;
    assign pwm_force = ctrl_ff[rcr_pkg::MODE_BIT];
    assign soft_enable = ctrl_ff[rcr_pkg::ENABLE_BIT];
endmodule // rcr_chan
`default_nettype wire

// >>> verification/rcr_top_assertions.sv
`default_nettype none
module rcr_top_assertions (
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire logic E_SLEEP_PIN_SEL,
    input wire logic F_SLEEP_PIN_SEL,
    input wire logic WR_EN,
    input wire logic [7:0] ADDR,
    input wire logic [7:0] WR_DATA,
    input wire logic [7:0] RD_DATA,
    input wire logic FIRST_SLEEP_PIN,
    input wire logic SECOND_SLEEP_PIN,
    input wire logic E_PIN_ENABLE,
    input wire logic F_PIN_ENABLE,
    input wire logic E_USE_SLEEP_CODE,
    input wire logic F_USE_SLEEP_CODE,
    input wire logic E_PWM_FORCE,
    input wire logic F_PWM_FORCE,
    input wire logic E_RUN,
    input wire logic F_RUN
);
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (RST);
    logic rst_ff, ae_ff, af_ff;
    // read data mirrors the register only after a quiet cycle, not at the strap load
    always_ff @(posedge CORE_CLK) begin
        rst_ff <= RST;
        ae_ff <= ADDR == 8'h26 && !WR_EN && !rst_ff;
        af_ff <= ADDR == 8'h27 && !WR_EN && !rst_ff;
    end
    AST_E_NORMAL: assert property (ae_ff && RD_DATA[5:4] == 2'h0 |-> !E_USE_SLEEP_CODE)
        else $error("fifth uses sleep code with field 00");
    AST_E_SLEEP: assert property (
        (!FIRST_SLEEP_PIN)[*6] ##0 (ae_ff && RD_DATA[5:4] == 2'h3 && !E_SLEEP_PIN_SEL)
        |-> E_USE_SLEEP_CODE)
        else $error("fifth misses sleep code");
    AST_F_SLEEP: assert property (
        (!SECOND_SLEEP_PIN)[*6] ##0 (af_ff && RD_DATA[5:4] == 2'h3 && F_SLEEP_PIN_SEL)
        |-> F_USE_SLEEP_CODE)
        else $error("sixth misses sleep code");
    AST_F_NORMAL: assert property (af_ff && RD_DATA[5:4] == 2'h0 |-> !F_USE_SLEEP_CODE)
        else $error("sixth uses sleep code with field 00");
    AST_E_MODE: assert property (ae_ff |-> E_PWM_FORCE == RD_DATA[1])
        else $error("fifth mode differs from bit 1");
    AST_F_MODE: assert property (af_ff |-> F_PWM_FORCE == RD_DATA[1])
        else $error("sixth mode differs from bit 1");
    AST_E_OFF: assert property (ae_ff && !RD_DATA[0] |-> !E_RUN)
        else $error("fifth runs with bit 0 clear");
    AST_F_OFF: assert property (af_ff && !RD_DATA[0] |-> !F_RUN)
        else $error("sixth runs with bit 0 clear");
    AST_TOP_ZERO: assert property (ae_ff || af_ff |-> RD_DATA[7:6] == 2'h0)
        else $error("bits 7:6 read nonzero");
    AST_E_PIN_OFF: assert property ((!E_PIN_ENABLE)[*6] |-> !E_RUN)
        else $error("fifth runs without its pin enable");
    AST_F_PIN_OFF: assert property ((!F_PIN_ENABLE)[*6] |-> !F_RUN)
        else $error("sixth runs without its pin enable");
    AST_F_DECODE: assert property (
        WR_EN && ADDR == 8'h27 ##1 ADDR == 8'h27 |=> RD_DATA == ($past(WR_DATA, 2) & 8'h3F))
        else $error("sixth register readback wrong");
endmodule // rcr_top_assertions
bind rcr_top rcr_top_assertions u_chk (.*);
`default_nettype wire

// >>> verification/test_rcr_top.sv
`default_nettype none
module test_rcr_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, rst = 1'b1, we = 1'b0, fp = 1'b1, sp = 1'b1;
    logic [1:0] pe = 2'h3;
    logic [7:0] adr = 8'h00, wd = 8'h00, rd, cd;
    logic eu, fu, ep, fw, er, fr;
    int n_mismatch = 0, cmp_count = 0, cyc = 0;
    always #25 clk = ~clk;
    rcr_top i_dut (.CORE_CLK(clk), .RST(rst), .E_STRAP(8'h8C), .F_STRAP(8'hFF),
        .E_SLEEP_PIN_SEL(1'b0), .F_SLEEP_PIN_SEL(1'b1), .WR_EN(we), .ADDR(adr),
        .WR_DATA(wd), .RD_DATA(rd), .FIRST_SLEEP_PIN(fp), .SECOND_SLEEP_PIN(sp),
        .ENABLE_INPUT_PINS(6'h00), .E_PIN_ENABLE(pe[0]), .F_PIN_ENABLE(pe[1]),
        .E_USE_SLEEP_CODE(eu), .F_USE_SLEEP_CODE(fu), .E_PWM_FORCE(ep),
        .F_PWM_FORCE(fw), .E_RUN(er), .F_RUN(fr));
    task give_verdict;
        $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk); #2;
        we = 1; adr = a; wd = d;
        @(posedge clk); #2;
        we = 0;
    endtask
    task rdc(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk); #2;
        adr = a;
        @(posedge clk); #2;
        chk("rd", e, rd);
    endtask
    // pins pass a synchronizer, so outputs are looked at only after it settles
    always @(posedge clk) begin
        cyc++;
        if (cyc > 3000) begin
            n_mismatch++;
            give_verdict;
        end
    end
    initial begin
        repeat (20) @(posedge clk); #2;
        rst = 0;
        rdc(8'h27, 8'h3F);
        rdc(8'h26, 8'h0C);
        chk("erun", 8'h00, {7'h0, er});
        wr(8'h27, 8'hFF);
        rdc(8'h27, 8'h3F);
        rdc(8'h28, 8'h00);
        $display("test reset and decode done");
        for (int i = 0; i < 4; i++) begin
            wr(8'h26, 8'h0C | i[7:0]);
            wr(8'h27, 8'h0C | i[7:0]);
            repeat (6) @(posedge clk); #2;
            chk("e_mode", {6'h0, i[1:0]}, {6'h0, ep, er});
            chk("f_mode", {6'h0, i[1:0]}, {6'h0, fw, fr});
        end
        // only the fifth pin enable high: a swap or a missing gate shows here
        pe = 2'h1;
        repeat (6) @(posedge clk); #2;
        chk("run_pin", 8'h02, {6'h0, er, fr});
        pe = 2'h3;
        $display("test mode and disable done");
        for (int i = 0; i < 3; i++) begin
            cd = (i == 2) ? 8'h0D : 8'h3D;
            fp = (i == 1);
            sp = (i == 0);
            wr(8'h26, cd);
            wr(8'h27, cd);
            repeat (6) @(posedge clk); #2;
            rdc(8'h26, cd);
            rdc(8'h27, cd);
            chk("sleep", {6'h0, i == 0, i == 1}, {6'h0, eu, fu});
        end
        $display("test sleep select done");
        // mid-run reset must bring back the factory patterns, not the last writes
        rst = 1'b1;
        repeat (3) @(posedge clk); #2;
        chk("rd_in_reset", 8'h00, rd);
        rst = 1'b0;
        rdc(8'h26, 8'h0C);
        rdc(8'h27, 8'h3F);
        $display("test second reset done");
        give_verdict;
    end
endmodule // test_rcr_top
`default_nettype wire
